/* File: design/dsps_pkg.sv */
`default_nettype none
package dsps_pkg;
	// Clock division
	localparam int unsigned PHASE_DIV = 4;
	localparam int unsigned BACKPLANE_DIV = 4800;
	localparam int unsigned BACKPLANE_HALF = BACKPLANE_DIV / 2;
	// Phase lengths in divided-clock counts
	localparam int unsigned INTEG_COUNTS = 1000;
	localparam int unsigned DEINT_MAX = 2000;
	localparam int unsigned ZERO_MIN = 1000;
	localparam int unsigned CYCLE_COUNTS = 4000;
	localparam int unsigned CYCLE_OSC = CYCLE_COUNTS * PHASE_DIV;
	localparam int unsigned FULL_SCALE = 2000;
	typedef enum logic [1:0]
	{
		PH_ZERO,
		PH_INTEG,
		PH_DEINT
	} phase_t;
endpackage : dsps_pkg
`default_nettype wire

/* File: design/dual_slope_phase_sequencer.sv */
// Function
// - Backplane square wave at clock over 4800
// - Segments in phase off, antiphase on
// - LED mode: no backplane, static sinks
// - Divide clock by four for counters
// - Integrate phase lasts exactly 1000 counts
// - De-integrate up to 2000, ends at zero
// - Zero phase absorbs unused de-integrate counts
// - Measure cycle always 4000 counts
// - Hold high blocks display latch updates
// - Updates resume after hold goes low
// - Twice reference gives 1999, the count ceiling
// - Latch sign at integrate end, drive polarity
// - Lamp check lights all segments, -1888
`default_nettype none
module dual_slope_phase_sequencer
(
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// Mode and user controls
	input wire logic led_mode_in,
	input wire logic hold_reading_input_in,
	input wire logic lamp_check_in,
	// Analog comparator
	input wire logic comp_zero_in,
	input wire logic comp_neg_in,
	// Analog switch controls
	output logic integrate_out,
	output logic reference_deintegrate_phase_out,
	output logic zero_correction_phase_out,
	output logic ref_neg_out,
	// Display
	output logic backplane_drive_out,
	output logic [6:0] seg_ones_out,
	output logic [6:0] seg_tens_out,
	output logic [6:0] seg_hund_out,
	output logic seg_thou_out,
	output logic seg_sign_out
);
	// ----------------------------------------
	// Seven-segment decode, gfedcba
	// ----------------------------------------
	function automatic logic [6:0] seg7(input logic [3:0] d);
		logic [6:0] s;
		s = 7'h00;
		case (d)
			4'h0: s = 7'h3F;
			4'h1: s = 7'h06;
			4'h2: s = 7'h5B;
			4'h3: s = 7'h4F;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6D;
			4'h6: s = 7'h7D;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7F;
			4'h9: s = 7'h6F;
			default: s = 7'h00;
		endcase
		return s;
	endfunction : seg7

	// ----------------------------------------
	// State
	// ----------------------------------------
	dsps_pkg::phase_t phase_r, phase_nxt;
	logic [1:0] pre_r, pre_nxt;
	logic [11:0] cyc_r, cyc_nxt;
	logic [11:0] half_r, half_nxt;
	logic bpw_r, bpw_nxt;
	logic [3:0] d0_r, d0_nxt, d1_r, d1_nxt, d2_r, d2_nxt;
	logic d3_r, d3_nxt;
	logic [3:0] l0_r, l0_nxt, l1_r, l1_nxt, l2_r, l2_nxt;
	logic l3_r, l3_nxt;
	logic sign_r, sign_nxt, lsign_r, lsign_nxt;
	logic [6:0] so_r, so_nxt, st_r, st_nxt, sh_r, sh_nxt;
	logic sth_r, sth_nxt, ssg_r, ssg_nxt;
	logic bpo_r, bpo_nxt, integ_r, integ_nxt;
	logic deint_r, deint_nxt, zero_r, zero_nxt;
	logic refn_r, refn_nxt;
	logic tick;

	always_comb
	begin
		tick = (pre_r == 2'(dsps_pkg::PHASE_DIV - 1));
		pre_nxt = pre_r + 2'h1;
		half_nxt = half_r + 12'h001;
		bpw_nxt = bpw_r;
		if (half_r == 12'(dsps_pkg::BACKPLANE_HALF - 1))
		begin
			half_nxt = 12'h000;
			bpw_nxt = ~bpw_r;
		end
		phase_nxt = phase_r;
		cyc_nxt = cyc_r;
		d0_nxt = d0_r;
		d1_nxt = d1_r;
		d2_nxt = d2_r;
		d3_nxt = d3_r;
		l0_nxt = l0_r;
		l1_nxt = l1_r;
		l2_nxt = l2_r;
		l3_nxt = l3_r;
		sign_nxt = sign_r;
		lsign_nxt = lsign_r;
		if (tick)
		begin
			// Whole cycle fixed; phase edges at fixed or crossing counts
			if (cyc_r == 12'(dsps_pkg::CYCLE_COUNTS - 1))
				cyc_nxt = 12'h000;
			else
				cyc_nxt = cyc_r + 12'h001;
			case (phase_r)
				dsps_pkg::PH_ZERO:
				begin
					// Zero phase takes whatever remains of the cycle
					if (cyc_r == 12'(dsps_pkg::CYCLE_COUNTS - 1))
						phase_nxt = dsps_pkg::PH_INTEG;
				end
				dsps_pkg::PH_INTEG:
				begin
					if (cyc_r == 12'(dsps_pkg::INTEG_COUNTS - 1))
					begin
						phase_nxt = dsps_pkg::PH_DEINT;
						sign_nxt = comp_neg_in;
						d0_nxt = 4'h0;
						d1_nxt = 4'h0;
						d2_nxt = 4'h0;
						d3_nxt = 1'b0;
					end
				end
				dsps_pkg::PH_DEINT:
				begin
					if (comp_zero_in || cyc_r ==
						12'(dsps_pkg::INTEG_COUNTS + dsps_pkg::DEINT_MAX - 1))
					begin
						phase_nxt = dsps_pkg::PH_ZERO;
						// Hold simply blocks capture; next result loads
						if (!hold_reading_input_in)
						begin
							l0_nxt = d0_r;
							l1_nxt = d1_r;
							l2_nxt = d2_r;
							l3_nxt = d3_r;
							lsign_nxt = sign_r;
						end
					end
					else if (d0_r != 4'h9)
						d0_nxt = d0_r + 4'h1;
					else
					begin
						d0_nxt = 4'h0;
						if (d1_r != 4'h9)
							d1_nxt = d1_r + 4'h1;
						else
						begin
							d1_nxt = 4'h0;
							if (d2_r != 4'h9)
								d2_nxt = d2_r + 4'h1;
							else
							begin
								d2_nxt = 4'h0;
								d3_nxt = 1'b1;
							end
						end
					end
				end
				default: phase_nxt = dsps_pkg::PH_ZERO;
			endcase
		end
		// Segment patterns, one = lit
		so_nxt = seg7(l0_r);
		st_nxt = seg7(l1_r);
		sh_nxt = seg7(l2_r);
		sth_nxt = l3_r;
		ssg_nxt = lsign_r;
		if (lamp_check_in)
		begin
			so_nxt = 7'h7F;
			st_nxt = 7'h7F;
			sh_nxt = 7'h7F;
			sth_nxt = 1'b1;
			ssg_nxt = 1'b1;
		end
		// LED sinks are static active-high; LCD xors with backplane
		if (!led_mode_in)
		begin
			so_nxt = so_nxt ^ {7{bpw_nxt}};
			st_nxt = st_nxt ^ {7{bpw_nxt}};
			sh_nxt = sh_nxt ^ {7{bpw_nxt}};
			sth_nxt = sth_nxt ^ bpw_nxt;
			ssg_nxt = ssg_nxt ^ bpw_nxt;
		end
		// Output flops follow the same next values as the state
		bpo_nxt = bpw_nxt & ~led_mode_in;
		integ_nxt = (phase_nxt == dsps_pkg::PH_INTEG);
		deint_nxt = (phase_nxt == dsps_pkg::PH_DEINT);
		zero_nxt = (phase_nxt == dsps_pkg::PH_ZERO);
		refn_nxt = ~sign_nxt;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			pre_r <= 2'h0;
			half_r <= 12'h000;
			bpw_r <= 1'b0;
			phase_r <= dsps_pkg::PH_ZERO;
			cyc_r <= 12'(dsps_pkg::INTEG_COUNTS + dsps_pkg::DEINT_MAX);
			d0_r <= 4'h0;
			d1_r <= 4'h0;
			d2_r <= 4'h0;
			d3_r <= 1'b0;
			l0_r <= 4'h0;
			l1_r <= 4'h0;
			l2_r <= 4'h0;
			l3_r <= 1'b0;
			sign_r <= 1'b0;
			lsign_r <= 1'b0;
			so_r <= 7'h00;
			st_r <= 7'h00;
			sh_r <= 7'h00;
			sth_r <= 1'b0;
			ssg_r <= 1'b0;
		end
		else if (ce_in)
		begin
			pre_r <= pre_nxt;
			half_r <= half_nxt;
			bpw_r <= bpw_nxt;
			phase_r <= phase_nxt;
			cyc_r <= cyc_nxt;
			d0_r <= d0_nxt;
			d1_r <= d1_nxt;
			d2_r <= d2_nxt;
			d3_r <= d3_nxt;
			l0_r <= l0_nxt;
			l1_r <= l1_nxt;
			l2_r <= l2_nxt;
			l3_r <= l3_nxt;
			sign_r <= sign_nxt;
			lsign_r <= lsign_nxt;
			so_r <= so_nxt;
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			sth_r <= sth_nxt;
			ssg_r <= ssg_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			bpo_r <= 1'b0;
			integ_r <= 1'b0;
			deint_r <= 1'b0;
			zero_r <= 1'b1;
			refn_r <= 1'b0;
		end
		else if (ce_in)
		begin
			bpo_r <= bpo_nxt;
			integ_r <= integ_nxt;
			deint_r <= deint_nxt;
			zero_r <= zero_nxt;
			refn_r <= refn_nxt;
		end
	end

	assign integrate_out = integ_r;
	assign reference_deintegrate_phase_out = deint_r;
	assign zero_correction_phase_out = zero_r;
	assign ref_neg_out = refn_r;
	assign backplane_drive_out = bpo_r;
	assign seg_ones_out = so_r;
	assign seg_tens_out = st_r;
	assign seg_hund_out = sh_r;
	assign seg_thou_out = sth_r;
	assign seg_sign_out = ssg_r;
endmodule : dual_slope_phase_sequencer
`default_nettype wire

/* File: bench/dsps_assertions.sv */
`default_nettype none
module dsps_assertions
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic led_mode_in,
	input wire logic integrate_out,
	input wire logic reference_deintegrate_phase_out,
	input wire logic zero_correction_phase_out,
	input wire logic backplane_drive_out
);
	timeunit 1ns / 1ps;
	logic [13:0] i_r, i_nxt, p_r, p_nxt, b_r, b_nxt;
	logic d_r, e_r, s_r, s_nxt;
	wire integ = integrate_out;
	wire dint = reference_deintegrate_phase_out;
	wire zero = zero_correction_phase_out;
	wire bkp = backplane_drive_out;
	always_comb
	begin
		i_nxt = integ ? i_r + 14'h1 : 14'h0;
		p_nxt = (integ && !d_r) ? 14'h1 : p_r + 14'h1;
		b_nxt = (bkp != e_r) ? 14'h1 : b_r + 14'h1;
		// Skips the partial first cycle after reset
		s_nxt = rstn_in && (s_r || integ);
	end
	always_ff @(posedge clk_in)
	begin
		i_r <= i_nxt;
		p_r <= p_nxt;
		b_r <= b_nxt;
		d_r <= integ;
		e_r <= bkp;
		s_r <= s_nxt;
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	a_phase_onehot: assert property ($onehot({integ, dint, zero}))
		else $error("phase not one-hot");
	a_integ_len: assert property ($fell(integ) |-> i_r == 14'hFA0)
		else $error("integrate length");
	a_deint_next: assert property ($fell(integ) |-> dint)
		else $error("no deint");
	a_zero_next: assert property ($fell(dint) |-> zero)
		else $error("no zero phase");
	a_cycle_len: assert property ($rose(integ) && s_r |-> p_r == 14'h3E80)
		else $error("cycle length");
	a_backplane_half: assert property (s_r && !led_mode_in &&
		!$past(led_mode_in) && $changed(bkp) |-> b_r == 14'h960)
		else $error("backplane half period");
	a_led_no_backplane: assert property (led_mode_in &&
		$past(led_mode_in) |-> !bkp) else $error("backplane in led mode");
	a_integ_from_zero: assert property ($rose(integ) |-> $past(zero))
		else $error("integrate not entered from zero phase");
endmodule : dsps_assertions
bind dual_slope_phase_sequencer dsps_assertions dsps_assertions_inst (.clk_in,
	.rstn_in, .led_mode_in, .integrate_out, .reference_deintegrate_phase_out,
	.zero_correction_phase_out, .backplane_drive_out);
`default_nettype wire

/* File: bench/seg_display_model.sv */
`default_nettype none
module seg_display_model
(
	input wire logic bkp_in,
	input wire logic [22:0] drive_in,
	output logic [22:0] lit_out
);
	timeunit 1ns / 1ps;
	// Lit where segment opposes backplane
	assign lit_out = drive_in ^ {23{bkp_in}};
endmodule : seg_display_model
`default_nettype wire

/* File: bench/test_dual_slope_phase_sequencer.sv */
`default_nettype none
module test_dual_slope_phase_sequencer;
	timeunit 1ns / 1ps;
	typedef struct {int n; logic ng; logic [22:0] e;} row_t;
	row_t rows[3] = '{'{456, 1'h0, {2'h0, 7'h66, 7'h6D, 7'h7D}},
		'{1089, 1'h1, {2'h3, 7'h3F, 7'h7F, 7'h6F}},
		'{1237, 1'h1, {2'h3, 7'h5B, 7'h4F, 7'h07}}};
	logic clk_in = 1'h0, rstn_in = 1'h0, led = 1'h0, hold = 1'h0;
	logic lamp = 1'h0, cz = 1'h0, cn = 1'h0, it, dint, ze, rn, bkp, th, sg;
	logic [6:0] so, st, sh;
	logic [22:0] lit;
	int error_cnt = 0, n_compared = 0;
	dual_slope_phase_sequencer dual_slope_phase_sequencer_inst (.clk_in,
		.rstn_in, .ce_in(1'h1), .led_mode_in(led),
		.hold_reading_input_in(hold), .lamp_check_in(lamp),
		.comp_zero_in(cz), .comp_neg_in(cn), .integrate_out(it),
		.reference_deintegrate_phase_out(dint),
		.zero_correction_phase_out(ze), .ref_neg_out(rn),
		.backplane_drive_out(bkp), .seg_ones_out(so), .seg_tens_out(st),
		.seg_hund_out(sh), .seg_thou_out(th), .seg_sign_out(sg));
	seg_display_model seg_display_model_inst (.bkp_in(bkp),
		.drive_in({sg, th, sh, st, so}), .lit_out(lit));
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	initial
	begin
		#1000000 error_cnt++;
		results;
	end
	task chk(input string nm, input logic [22:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task results;
		$display("compared %0d failed %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	task conv(input int n, input logic ng, h);
		int i;
		@(posedge clk_in);
		cn <= ng;
		hold <= h;
		for (i = 0; i < 20000 && !dint; i++)
			@(negedge clk_in);
		chk("ref_neg", !ng, rn);
		// Seen first at tick n+1, so n counts precede it
		repeat (4 * n + 1) @(posedge clk_in);
		cz <= 1'h1;
		for (i = 0; i < 9000 && dint; i++)
			@(negedge clk_in);
		@(posedge clk_in);
		cz <= 1'h0;
		repeat (3) @(negedge clk_in);
		$display("conversion %0d done", n);
	endtask : conv
	initial
	begin
		repeat (12) @(negedge clk_in);
		chk("reset", 23'h2, {so, it, dint, ze, bkp});
		$display("reset check done");
		@(posedge clk_in);
		rstn_in <= 1'h1;
		foreach (rows[k])
		begin
			conv(rows[k].n, rows[k].ng, 1'h0);
			chk("display", rows[k].e, lit);
		end
		conv(1998, 1'h0, 1'h1);
		chk("held", rows[2].e, lit);
		@(posedge clk_in);
		led <= 1'h1;
		conv(1998, 1'h0, 1'h0);
		chk("resumed", {2'h1, 7'h6F, 7'h6F, 7'h7F}, lit);
		@(posedge clk_in);
		lamp <= 1'h1;
		repeat (3) @(negedge clk_in);
		chk("lamp", 23'h7FFFFF, lit);
		$display("lamp check done");
		// Reset in mid-run must beat lamp check and clear the display
		@(posedge clk_in);
		rstn_in <= 1'h0;
		repeat (2) @(negedge clk_in);
		chk("mid reset", 23'h2, {so, it, dint, ze, bkp});
		chk("mid reset lit", 23'h0, lit);
		$display("mid-run reset done");
		results;
	end
endmodule : test_dual_slope_phase_sequencer
`default_nettype wire
